// [behc_ctrl.sv]
`timescale 1ns/1ps
// What this block does
// RULE_01: Delay grant when request meets first bus state
// RULE_02: Outside timer raises bus fault on timeout
// RULE_03: Strobe drops two and half clocks after fault
// RULE_04: Float buses while fault held, stack after
// RULE_05: Stack PC/SR, error info, vector, then handler
// RULE_06: Fault with halt: float, wait, rerun same cycle
// RULE_07: Outside releases fault a clock before halt (behc_far releases it two clocks before)
// RULE_08: Never rerun read-modify-write; take exception instead
// RULE_09: Halt stops cycles, float buses after cycle
// RULE_10: Single step runs exactly one bus cycle
// RULE_11: Arbitration continues while halted, floats controls
// RULE_12: Second fault before next instruction halts device
// RULE_13: Reruns never count toward double fault
// RULE_14: Fault before first instruction is double fault
// RULE_15: Outside asserts reset and halt together
// RULE_16: Reset loads stack pointer, PC, mask seven
// RULE_17: Reset instruction drives reset line 124 clocks
// RULE_18: Reset with halt ten clocks resets device
// RULE_19: Async inputs sampled on falling clock edge
module behc_ctrl (
	input  wire logic             core_clk,
	input  wire logic             reset,
	input  wire logic             bus_fault_in,
	input  wire logic             halt_in,
	input  wire logic             bus_req_in,
	input  wire logic             transfer_ack_in,
	input  wire logic             reset_line_in,
	input  wire logic             core_cycle_req,
	input  wire logic             core_cycle_rmw,
	input  wire logic             core_cycle_write,
	input  wire logic [2:0]       core_fc,
	input  wire logic [7:0]       core_wdata,
	input  wire logic             core_step_done,
	input  wire logic             core_instr_start,
	input  wire logic             core_reset_instr,
	output logic                  addr_strobe,
	output logic                  bus_grant_out,
	output logic                  bus_float,
	output logic                  ctrl_float,
	output logic                  write_out,
	output logic      [2:0]       fc_out,
	output logic      [7:0]       wdata_out,
	output logic                  cycle_done,
	output logic                  cycle_rerun,
	output logic                  halted,
	output logic                  double_fault,
	output logic                  reset_line_out,
	output logic                  reset_line_oe_n,
	output behc_pkg::behc_seq_t   seq_step,
	output logic      [23:0]      vec_addr,
	output logic      [2:0]       int_mask
);
	// ------------------------------------------------------------------------
	// Declarations
	// ------------------------------------------------------------------------
	behc_pkg::behc_pins_t  pins_raw;
	behc_pkg::behc_pins_t  pins_s;
	behc_pkg::behc_state_t state_q;
	behc_pkg::behc_state_t state_d;
	behc_pkg::behc_seq_t   seq_d;
	logic [6:0]            cnt_q;
	logic [6:0]            cnt_d;
	logic [3:0]            ext_cnt_q;
	logic                  ext_hold;
	logic                  ext_fire;
	logic                  rerun_q;
	logic                  rmw_q;
	logic                  window_q;
	logic                  grant_d;
	logic                  strobe_d;

	// ------------------------------------------------------------------------
	// Input synchronisation
	// ------------------------------------------------------------------------
	assign pins_raw = '{fault: bus_fault_in, halt: halt_in, req: bus_req_in,
		ack: transfer_ack_in, rst: reset_line_in};

	behc_sync #(
		.W ($bits(behc_pkg::behc_pins_t))
	) u_sync (
		.core_clk (core_clk),
		.reset    (reset),
		.d        (pins_raw),
		.q        (pins_s)
	);

	// ------------------------------------------------------------------------
	// External reset detection
	// ------------------------------------------------------------------------
	// Own drive of the reset line is not taken as an outside reset
	assign ext_hold = pins_s.rst && pins_s.halt &&
		(state_q != behc_pkg::ST_RSTI); // RULE_15
	assign ext_fire = ext_hold && (ext_cnt_q == behc_pkg::EXT_RST_LAST);

	// Count cycles of reset and halt held together
	always_ff @(posedge core_clk) begin // RULE_18
		if (reset || !ext_hold || ext_fire) begin
			ext_cnt_q <= 4'h0;
		end else begin
			ext_cnt_q <= ext_cnt_q + 4'h1;
		end
	end

	// ------------------------------------------------------------------------
	// Bus control next state
	// ------------------------------------------------------------------------
	always_comb begin
		state_d = state_q;
		cnt_d   = cnt_q;
		unique case (state_q)
			behc_pkg::ST_IDLE: begin
				if (core_reset_instr) begin
					state_d = behc_pkg::ST_RSTI;
					cnt_d   = 7'h00;
				end else if (pins_s.halt) begin
					state_d = behc_pkg::ST_HALT; // RULE_09
				end else if (core_cycle_req && !pins_s.req && !bus_grant_out) begin
					state_d = behc_pkg::ST_FIRST;
				end
			end
			behc_pkg::ST_FIRST: begin
				state_d = behc_pkg::ST_ASRT;
			end
			behc_pkg::ST_ASRT: begin
				if (pins_s.fault) begin
					state_d = behc_pkg::ST_FLT;
					cnt_d   = 7'h00;
				end else if (pins_s.ack) begin
					// Halt seen by the end of the cycle stops the next one
					state_d = pins_s.halt ? behc_pkg::ST_HALT
						: behc_pkg::ST_IDLE; // RULE_10
				end
			end
			behc_pkg::ST_FLT: begin
				if (cnt_q == behc_pkg::FAULT_AS_LAST) begin // RULE_03
					if (rerun_q) begin
						state_d = behc_pkg::ST_RHALT; // RULE_13
					end else if (window_q) begin
						state_d = behc_pkg::ST_DBLF; // RULE_12 RULE_14
					end else begin
						state_d = behc_pkg::ST_WAITF;
					end
				end else begin
					cnt_d = cnt_q + 7'h01;
				end
			end
			behc_pkg::ST_WAITF: begin
				if (!pins_s.fault) begin
					state_d = behc_pkg::ST_IDLE; // RULE_04
				end
			end
			behc_pkg::ST_RHALT: begin
				if (!pins_s.halt) begin
					state_d = behc_pkg::ST_FIRST; // RULE_06
				end
			end
			behc_pkg::ST_HALT: begin
				if (!pins_s.halt) begin
					state_d = behc_pkg::ST_IDLE;
				end
			end
			behc_pkg::ST_DBLF: begin
				state_d = behc_pkg::ST_DBLF;
			end
			behc_pkg::ST_RSTI: begin
				if (cnt_q == behc_pkg::RSTI_LAST) begin // RULE_17
					state_d = behc_pkg::ST_IDLE;
				end else begin
					cnt_d = cnt_q + 7'h01;
				end
			end
		endcase
		if (ext_fire) begin
			state_d = behc_pkg::ST_IDLE; // RULE_18
		end
	end

	// State and cycle counter
	always_ff @(posedge core_clk) begin
		if (reset) begin
			state_q <= behc_pkg::ST_IDLE;
			cnt_q   <= 7'h00;
		end else begin
			state_q <= state_d;
			cnt_q   <= cnt_d;
		end
	end

	// Rerun decision taken when the fault hits a running cycle
	always_ff @(posedge core_clk) begin
		if (reset) begin
			rerun_q <= 1'b0;
		end else if (state_q == behc_pkg::ST_ASRT && pins_s.fault) begin
			rerun_q <= pins_s.halt && !rmw_q; // RULE_06 RULE_08
		end
	end

	// Cycle attributes, kept untouched across a rerun
	always_ff @(posedge core_clk) begin
		if (reset) begin
			rmw_q     <= 1'b0;
			write_out <= 1'b0;
			fc_out    <= 3'h0;
			wdata_out <= 8'h00;
		end else if (state_q == behc_pkg::ST_IDLE &&
			state_d == behc_pkg::ST_FIRST) begin
			rmw_q     <= core_cycle_rmw;
			write_out <= core_cycle_write;
			fc_out    <= core_fc;
			wdata_out <= core_wdata;
		end
	end

	// ------------------------------------------------------------------------
	// Double fault window and sequence steps
	// ------------------------------------------------------------------------
	// Open from reset or exception start until an instruction begins
	always_ff @(posedge core_clk) begin
		if (reset || ext_fire) begin
			window_q <= 1'b1; // RULE_14
		end else if (state_q == behc_pkg::ST_WAITF &&
			state_d == behc_pkg::ST_IDLE) begin
			window_q <= 1'b1; // RULE_12
		end else if (core_instr_start) begin
			window_q <= 1'b0;
		end
	end

	// Next sequence step
	always_comb begin
		seq_d = seq_step;
		if (ext_fire) begin
			seq_d = behc_pkg::SEQ_RST_STK;
		end else if (state_q == behc_pkg::ST_WAITF &&
			state_d == behc_pkg::ST_IDLE) begin
			seq_d = behc_pkg::SEQ_STK_PC;
		end else if (core_step_done) begin
			unique case (seq_step) // RULE_05 RULE_16
				behc_pkg::SEQ_NONE:    seq_d = behc_pkg::SEQ_NONE;
				behc_pkg::SEQ_STK_PC:  seq_d = behc_pkg::SEQ_STK_ERR;
				behc_pkg::SEQ_STK_ERR: seq_d = behc_pkg::SEQ_VEC_BE;
				behc_pkg::SEQ_VEC_BE:  seq_d = behc_pkg::SEQ_HANDLER;
				behc_pkg::SEQ_HANDLER: seq_d = behc_pkg::SEQ_NONE;
				behc_pkg::SEQ_RST_STK: seq_d = behc_pkg::SEQ_RST_PC;
				behc_pkg::SEQ_RST_PC:  seq_d = behc_pkg::SEQ_NONE;
			endcase
		end
	end

	// Sequence step, vector address and interrupt mask
	always_ff @(posedge core_clk) begin
		if (reset) begin
			seq_step <= behc_pkg::SEQ_RST_STK;
			vec_addr <= behc_pkg::VEC_STK_ADDR;
			int_mask <= behc_pkg::INT_MASK_RST;
		end else begin
			seq_step <= seq_d;
			if (seq_d == behc_pkg::SEQ_RST_PC) begin
				vec_addr <= behc_pkg::VEC_PC_ADDR;
			end else if (seq_d == behc_pkg::SEQ_VEC_BE) begin
				vec_addr <= behc_pkg::VEC_BE_ADDR;
			end else begin
				vec_addr <= behc_pkg::VEC_STK_ADDR;
			end
			if (ext_fire) begin
				int_mask <= behc_pkg::INT_MASK_RST; // RULE_16
			end
		end
	end

	// ------------------------------------------------------------------------
	// Registered outputs
	// ------------------------------------------------------------------------
	// Grant held back one edge when the request meets the first bus state
	assign grant_d  = pins_s.req && (state_q != behc_pkg::ST_FIRST); // RULE_01
	assign strobe_d = (state_d == behc_pkg::ST_ASRT) ||
		(state_d == behc_pkg::ST_FLT);

	always_ff @(posedge core_clk) begin
		if (reset) begin
			addr_strobe     <= 1'b0;
			bus_grant_out   <= 1'b0;
			bus_float       <= 1'b0;
			ctrl_float      <= 1'b0;
			cycle_done      <= 1'b0;
			cycle_rerun     <= 1'b0;
			halted          <= 1'b0;
			double_fault    <= 1'b0;
			reset_line_out  <= 1'b0;
			reset_line_oe_n <= 1'b1;
		end else begin
			addr_strobe     <= strobe_d;
			bus_grant_out   <= grant_d; // RULE_11
			bus_float       <= grant_d ||
				(state_d inside {behc_pkg::ST_WAITF, behc_pkg::ST_RHALT,
				behc_pkg::ST_HALT, behc_pkg::ST_DBLF}); // RULE_04 RULE_09
			ctrl_float      <= grant_d && !strobe_d; // RULE_11
			cycle_done      <= (state_q == behc_pkg::ST_ASRT) &&
				!pins_s.fault && pins_s.ack;
			cycle_rerun     <= (state_q == behc_pkg::ST_RHALT) && !pins_s.halt;
			halted          <= state_d inside {behc_pkg::ST_RHALT,
				behc_pkg::ST_HALT, behc_pkg::ST_DBLF};
			double_fault    <= (state_d == behc_pkg::ST_DBLF);
			reset_line_out  <= (state_d == behc_pkg::ST_RSTI); // RULE_17
			reset_line_oe_n <= (state_d != behc_pkg::ST_RSTI);
		end
	end

	// ------------------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------------------
	logic [7:0] drv_len_q;

	// Length of the current reset line drive
	always_ff @(posedge core_clk) begin
		if (reset || !reset_line_out) begin
			drv_len_q <= 8'h00;
		end else begin
			drv_len_q <= drv_len_q + 8'h01;
		end
	end

	property p_grant_delay;
		@(posedge core_clk) disable iff (reset)
		(state_q == behc_pkg::ST_FIRST && pins_s.req && !bus_grant_out)
		|=> !bus_grant_out ##1 (bus_grant_out || !$past(pins_s.req));
	endproperty
	a_grant_delay: assert property (p_grant_delay) // RULE_01
		else $error("grant not delayed after first bus state");

	property p_strobe_release;
		@(posedge core_clk) disable iff (reset)
		(state_q == behc_pkg::ST_ASRT && pins_s.fault && !ext_fire)
		|=> addr_strobe [*2] ##1 !addr_strobe;
	endproperty
	a_strobe_release: assert property (p_strobe_release) // RULE_03
		else $error("strobe release after fault mistimed");

	property p_fault_float;
		@(posedge core_clk) disable iff (reset)
		(state_q == behc_pkg::ST_WAITF && pins_s.fault && !ext_fire)
		|=> (state_q == behc_pkg::ST_WAITF) && bus_float &&
		(seq_step == $past(seq_step));
	endproperty
	a_fault_float: assert property (p_fault_float) // RULE_04
		else $error("stacking began or bus driven while fault held");

	property p_exc_order;
		@(posedge core_clk) disable iff (reset)
		(seq_step == behc_pkg::SEQ_STK_ERR && core_step_done && !ext_fire)
		|=> (seq_step == behc_pkg::SEQ_VEC_BE) &&
		(vec_addr == behc_pkg::VEC_BE_ADDR);
	endproperty
	a_exc_order: assert property (p_exc_order) // RULE_05
		else $error("bus error vector fetch out of order");

	property p_rerun_same;
		@(posedge core_clk) disable iff (reset)
		(state_q == behc_pkg::ST_RHALT && !pins_s.halt && !ext_fire)
		|=> (state_q == behc_pkg::ST_FIRST) && cycle_rerun &&
		$stable(fc_out) && $stable(wdata_out) && $stable(write_out);
	endproperty
	a_rerun_same: assert property (p_rerun_same) // RULE_06
		else $error("rerun did not repeat the same cycle");

	property p_no_rmw_rerun;
		@(posedge core_clk) disable iff (reset)
		(state_q == behc_pkg::ST_ASRT && pins_s.fault && rmw_q && !ext_hold)
		|-> ##3 (state_q != behc_pkg::ST_RHALT);
	endproperty
	a_no_rmw_rerun: assert property (p_no_rmw_rerun) // RULE_08
		else $error("read-modify-write cycle was rerun");

	property p_halt_after_cycle;
		@(posedge core_clk) disable iff (reset)
		(state_q == behc_pkg::ST_ASRT && pins_s.ack && !pins_s.fault &&
		pins_s.halt && !ext_fire)
		|=> (state_q == behc_pkg::ST_HALT) && cycle_done && bus_float;
	endproperty
	a_halt_after_cycle: assert property (p_halt_after_cycle) // RULE_10
		else $error("halt after cycle not honoured");

	property p_double_fault;
		@(posedge core_clk) disable iff (reset)
		(state_q == behc_pkg::ST_ASRT && pins_s.fault && window_q &&
		!pins_s.halt && !ext_hold)
		|-> ##4 double_fault && halted;
	endproperty
	a_double_fault: assert property (p_double_fault) // RULE_12
		else $error("fault inside window did not halt");

	property p_reset_drive;
		@(posedge core_clk) disable iff (reset)
		$fell(reset_line_out) |-> (drv_len_q == 8'(behc_pkg::RSTI_CYC));
	endproperty
	a_reset_drive: assert property (p_reset_drive) // RULE_17
		else $error("reset line drive length wrong");

	property p_ext_reset;
		@(posedge core_clk) disable iff (reset)
		ext_fire |=> (seq_step == behc_pkg::SEQ_RST_STK) &&
		(vec_addr == behc_pkg::VEC_STK_ADDR) &&
		(int_mask == behc_pkg::INT_MASK_RST) && !double_fault;
	endproperty
	a_ext_reset: assert property (p_ext_reset) // RULE_16
		else $error("outside reset did not restart sequence");

	c_rerun: cover property (@(posedge core_clk) disable iff (reset)
		cycle_rerun);
	c_dblf: cover property (@(posedge core_clk) disable iff (reset)
		$rose(double_fault));
	c_handler: cover property (@(posedge core_clk) disable iff (reset)
		seq_step == behc_pkg::SEQ_HANDLER);
	c_rsti: cover property (@(posedge core_clk) disable iff (reset)
		$fell(reset_line_out));
endmodule // behc_ctrl

// [behc_pkg.sv]
// ----------------------------------------------------------------------------
// Shared constants and types
// ----------------------------------------------------------------------------
package behc_pkg;

	// ------------------------------------------------------------------------
	// Clock and timing
	// ------------------------------------------------------------------------
	localparam int CLK_NS        = 20;   // core_clk period, 50 MHz
	localparam int FAULT_AS_NS   = 50;   // Fault recognition to strobe release
	// Recognition lands half a period before the next rising edge
	localparam int FAULT_AS_CYC  = (FAULT_AS_NS - CLK_NS / 2) / CLK_NS;
	localparam int RSTI_CYC      = 124;  // Reset line drive length
	localparam int EXT_RST_CYC   = 10;   // Reset plus halt hold length
	localparam int POWERUP_MS    = 100;  // Power-on reset length, far side

	localparam logic [6:0] FAULT_AS_LAST = 7'(FAULT_AS_CYC - 1);
	localparam logic [6:0] RSTI_LAST     = 7'(RSTI_CYC - 1);
	localparam logic [3:0] EXT_RST_LAST  = 4'(EXT_RST_CYC - 1);

	// ------------------------------------------------------------------------
	// Vector addresses and reset values
	// ------------------------------------------------------------------------
	localparam logic [23:0] VEC_STK_ADDR = 24'h000000;
	localparam logic [23:0] VEC_PC_ADDR  = 24'h000004;
	localparam logic [23:0] VEC_BE_ADDR  = 24'h000008;
	localparam logic [2:0]  INT_MASK_RST = 3'h7;

	// ------------------------------------------------------------------------
	// Bus control states
	// ------------------------------------------------------------------------
	typedef enum logic [8:0] {
		ST_IDLE  = 9'h001,
		ST_FIRST = 9'h002,
		ST_ASRT  = 9'h004,
		ST_FLT   = 9'h008,
		ST_WAITF = 9'h010,
		ST_RHALT = 9'h020,
		ST_HALT  = 9'h040,
		ST_DBLF  = 9'h080,
		ST_RSTI  = 9'h100
	} behc_state_t;

	// ------------------------------------------------------------------------
	// Exception and reset sequence steps
	// ------------------------------------------------------------------------
	typedef enum logic [6:0] {
		SEQ_NONE    = 7'h01,
		SEQ_STK_PC  = 7'h02,
		SEQ_STK_ERR = 7'h04,
		SEQ_VEC_BE  = 7'h08,
		SEQ_HANDLER = 7'h10,
		SEQ_RST_STK = 7'h20,
		SEQ_RST_PC  = 7'h40
	} behc_seq_t;

	// ------------------------------------------------------------------------
	// Pin inputs, synchronised as one group
	// ------------------------------------------------------------------------
	typedef struct packed {
		logic fault;
		logic halt;
		logic req;
		logic ack;
		logic rst;
	} behc_pins_t;

endpackage

// [behc_sync.sv]
`timescale 1ns/1ps
// ----------------------------------------------------------------------------
// Falling edge two stage synchroniser
// ----------------------------------------------------------------------------
module behc_sync #(
	parameter int W = 5
) (
	input  wire logic         core_clk,
	input  wire logic         reset,
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);
	logic [W-1:0] meta_q;

	// One pair of flops per bit, both clocked on the falling edge
	for (genvar i = 0; i < W; i++) begin : g_bit
		always_ff @(negedge core_clk) begin // RULE_19
			if (reset) begin
				meta_q[i] <= 1'b0;
				q[i]      <= 1'b0;
			end else begin
				meta_q[i] <= d[i];
				q[i]      <= meta_q[i];
			end
		end
	end
endmodule // behc_sync

// [behc_far.sv]
`timescale 1ns/1ps
// Far side: strobe timer, ack source, halt and reset drivers
module behc_far (
	input  wire logic       core_clk,
	input  wire logic       reset,
	input  wire logic       addr_strobe,
	input  wire logic       reset_line_out,
	input  wire logic       reset_line_oe_n,
	input  wire logic [7:0] ack_wait,
	input  wire logic [7:0] fault_wait,
	input  wire logic       halt_cmd,
	input  wire logic       ext_rst,
	output logic            bus_fault_in,
	output logic            halt_in,
	output logic            transfer_ack_in,
	output logic            reset_line_in
);
	logic [7:0] stb_cnt_q;
	logic [1:0] hold_q;
	logic       keep_halt_q;

	// Counts cycles since the strobe rose; ff means never answer
	always_ff @(posedge core_clk) begin
		if (reset || !addr_strobe) begin
			stb_cnt_q <= 8'h00;
		end else if (stb_cnt_q != 8'hff) begin
			stb_cnt_q <= stb_cnt_q + 8'h01;
		end
	end

	// Timeout raises the fault, held a few cycles past the strobe
	always_ff @(posedge core_clk) begin
		if (reset) begin
			bus_fault_in <= 1'b0;
			hold_q <= 2'h0;
		end else if (addr_strobe && fault_wait != 8'hff &&
			stb_cnt_q >= fault_wait) begin
			bus_fault_in <= 1'b1;
			hold_q <= 2'h0;
		end else if (bus_fault_in && !addr_strobe) begin
			hold_q <= hold_q + 2'h1;
			bus_fault_in <= (hold_q != 2'h3);
		end
	end

	// Ack after the chosen wait, dropped once the strobe ends
	always_ff @(posedge core_clk) begin
		transfer_ack_in <= !reset && addr_strobe && ack_wait != 8'hff &&
			stb_cnt_q >= ack_wait;
	end

	// Halt outlives a fault by two cycles; reset source asserts both lines
	always_ff @(posedge core_clk) begin
		keep_halt_q <= !reset && bus_fault_in && halt_in;
		halt_in <= !reset && (halt_cmd || ext_rst || keep_halt_q);
	end

	// Shared reset wire level
	assign reset_line_in = ext_rst || (!reset_line_oe_n && reset_line_out);
endmodule // behc_far

// [behc_ctrl_bench.sv]
`timescale 1ns/1ps
// Self-checking bench for fault, halt and reset control
module behc_ctrl_bench;
	logic                core_clk, reset, bus_req_in, core_cycle_req;
	logic                core_cycle_rmw, core_cycle_write, core_step_done;
	logic                core_instr_start, core_reset_instr, halt_cmd;
	logic                ext_rst, bus_fault_in, halt_in, transfer_ack_in;
	logic                reset_line_in, addr_strobe, bus_grant_out;
	logic                bus_float, ctrl_float, write_out, cycle_done;
	logic                cycle_rerun, halted, double_fault;
	logic                reset_line_out, reset_line_oe_n;
	logic [2:0]          core_fc, fc_out, int_mask;
	logic [7:0]          core_wdata, wdata_out, ack_wait, fault_wait;
	logic [23:0]         vec_addr;
	logic [15:0]         seed;
	behc_pkg::behc_seq_t seq_step;
	int                  bad_count, total_checks, cycles, reruns, n, k;

	behc_ctrl u_behc_ctrl (.*);
	behc_far  u_behc_far (.*);

	// Free-running clock
	initial begin
		core_clk = 1'b0;
		forever #10 core_clk = ~core_clk;
	end

	// Hang guard and rerun counter
	always @(posedge core_clk) begin
		cycles++;
		reruns += (cycle_rerun === 1'b1);
		if (cycles == 6000) begin
			bad_count++;
			complete_run();
		end
	end

	function automatic logic [15:0] lfsr(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction

	task automatic check(input logic ok, input string msg);
		total_checks++;
		if (ok !== 1'b1) begin
			bad_count++;
			$display("CHECK FAILED at %0t: %s", $time, msg);
		end
	endtask

	task automatic tick(input int c);
		repeat (c) @(negedge core_clk);
	endtask

	task automatic wait_lvl(ref logic s, input logic v, input string m);
		int w;
		w = 0;
		while (s !== v && w < 300) begin
			tick(1);
			w++;
		end
		check(w < 300, m);
	endtask

	task automatic pulse(ref logic s);
		s = 1'b1;
		tick(1);
		s = 1'b0;
	endtask

	task automatic attrs_ok();
		check(fc_out === core_fc && wdata_out === core_wdata &&
			write_out === core_cycle_write, "cycle attributes");
	endtask

	// Requests a cycle with random attributes, waits for the strobe
	task automatic start_cyc(input logic m);
		seed = lfsr(seed);
		core_fc = seed[2:0];
		core_wdata = seed[10:3];
		core_cycle_write = seed[15];
		core_cycle_rmw = m;
		core_cycle_req = 1'b1;
		wait_lvl(addr_strobe, 1'b1, "strobe rise");
		attrs_ok();
	endtask

	// Faulting cycle, request dropped once the strobe ends
	task automatic fault_cyc(input logic m);
		fault_wait = 8'h01;
		start_cyc(m);
		wait_lvl(addr_strobe, 1'b0, "strobe end");
		core_cycle_req = 1'b0;
		fault_wait = 8'hff;
	endtask

	// Walks the exception steps after the fault is released
	task automatic stack();
		behc_pkg::behc_seq_t exp[4];
		exp = '{behc_pkg::SEQ_STK_ERR, behc_pkg::SEQ_VEC_BE,
			behc_pkg::SEQ_HANDLER, behc_pkg::SEQ_NONE};
		n = 0;
		while (seq_step !== behc_pkg::SEQ_STK_PC && n < 50) begin
			tick(1);
			n++;
		end
		check(n < 50 && bus_fault_in === 1'b0, "stacking start");
		for (int j = 0; j < 4; j++) begin
			pulse(core_step_done);
			check(seq_step === exp[j], "exception step");
		end
		pulse(core_step_done);
	endtask

	task automatic boot();
		check(seq_step === behc_pkg::SEQ_RST_STK && vec_addr ===
			behc_pkg::VEC_STK_ADDR, "stack vector");
		pulse(core_step_done);
		check(seq_step === behc_pkg::SEQ_RST_PC && vec_addr ===
			behc_pkg::VEC_PC_ADDR, "pc vector");
		pulse(core_step_done);
		check(seq_step === behc_pkg::SEQ_NONE, "boot end");
		pulse(core_instr_start);
	endtask

	task automatic ext_reset();
		ext_rst <= 1'b1;
		tick(14);
		ext_rst <= 1'b0;
		tick(4);
		check(double_fault === 1'b0 && int_mask === behc_pkg::INT_MASK_RST
			&& seq_step === behc_pkg::SEQ_RST_STK, "ext reset");
	endtask

	task automatic complete_run();
		$display("checks %0d mismatches %0d", total_checks, bad_count);
		if (bad_count == 0 && total_checks > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	// Main sequence
	initial begin
		{reset, bus_req_in, core_cycle_req, core_cycle_rmw} = 4'h8;
		{core_cycle_write, core_step_done, core_instr_start} = 3'h0;
		{core_reset_instr, halt_cmd, ext_rst, core_fc} = 6'h00;
		core_wdata = 8'h00;
		ack_wait = 8'h01;
		fault_wait = 8'hff;
		seed = 16'hd8d4;
		tick(4);
		reset = 1'b0;
		tick(1);
		check(reset_line_oe_n === 1'b1 && int_mask ===
			behc_pkg::INT_MASK_RST, "reset values");
		boot();
		for (int i = 0; i < 8; i++) begin
			ack_wait = {6'h00, seed[5:4]};
			start_cyc(1'b0);
			wait_lvl(cycle_done, 1'b1, "cycle done");
			core_cycle_req = 1'b0;
			tick(3);
		end
		// Request lands in the first bus state: grant one edge late
		bus_req_in <= 1'b1;
		tick(1);
		core_cycle_req = 1'b1;
		tick(2);
		check(bus_grant_out === 1'b0, "grant too early");
		tick(1);
		check(bus_grant_out === 1'b1, "grant missing");
		bus_req_in <= 1'b0;
		wait_lvl(cycle_done, 1'b1, "grant cycle done");
		core_cycle_req = 1'b0;
		tick(3);
		fault_wait = 8'h01;
		ack_wait = 8'hff;
		start_cyc(1'b0);
		wait_lvl(bus_fault_in, 1'b1, "fault pin");
		for (n = 0; addr_strobe === 1'b1 && n < 9; n++) tick(1);
		check(n >= 4 && n <= 5, "strobe release");
		core_cycle_req = 1'b0;
		fault_wait = 8'hff;
		check(bus_float === 1'b1 && seq_step === behc_pkg::SEQ_NONE,
			"float in fault");
		stack();
		pulse(core_instr_start);
		fault_cyc(1'b0);
		tick(8);
		check(seq_step === behc_pkg::SEQ_STK_PC, "second exception");
		fault_cyc(1'b0);
		tick(4);
		check(double_fault === 1'b1 && halted === 1'b1, "dbl");
		ext_reset();
		fault_cyc(1'b0);
		tick(4);
		check(double_fault === 1'b1 && halted === 1'b1, "boot");
		ext_reset();
		boot();
		halt_cmd = 1'b1;
		fault_wait = 8'h01;
		start_cyc(1'b0);
		for (k = 0; k < 2; k++) begin
			wait_lvl(addr_strobe, 1'b0, "rerun end");
			tick(2);
			check(halted === 1'b1 && bus_float === 1'b1, "rerun");
			tick(6);
			if (k == 1) begin
				fault_wait = 8'hff;
				ack_wait = 8'h01;
			end
			halt_cmd = 1'b0;
			wait_lvl(cycle_rerun, 1'b1, "rerun pulse");
			halt_cmd = (k == 0);
			wait_lvl(addr_strobe, 1'b1, "rerun strobe");
			attrs_ok();
		end
		wait_lvl(cycle_done, 1'b1, "rerun done");
		core_cycle_req = 1'b0;
		check(double_fault === 1'b0 && reruns == 2, "reruns");
		tick(3);
		halt_cmd = 1'b1;
		fault_wait = 8'h01;
		start_cyc(1'b1);
		wait_lvl(addr_strobe, 1'b0, "rmw end");
		core_cycle_req = 1'b0;
		halt_cmd = 1'b0;
		fault_wait = 8'hff;
		stack();
		check(reruns == 2 && double_fault === 1'b0, "rmw");
		pulse(core_instr_start);
		halt_cmd = 1'b1;
		tick(4);
		check(halted === 1'b1 && bus_float === 1'b1, "halt");
		core_cycle_req = 1'b1;
		bus_req_in = 1'b1;
		tick(6);
		check(addr_strobe === 1'b0 && bus_grant_out === 1'b1 &&
			ctrl_float === 1'b1, "grant halted");
		bus_req_in = 1'b0;
		tick(4);
		halt_cmd = 1'b0;
		ack_wait = 8'h02;
		wait_lvl(addr_strobe, 1'b1, "step strobe");
		halt_cmd = 1'b1;
		wait_lvl(cycle_done, 1'b1, "step done");
		tick(6);
		check(addr_strobe === 1'b0 && halted === 1'b1, "step");
		halt_cmd = 1'b0;
		wait_lvl(cycle_done, 1'b1, "resume");
		core_cycle_req = 1'b0;
		tick(3);
		pulse(core_reset_instr);
		wait_lvl(reset_line_oe_n, 1'b0, "reset drive");
		for (n = 0; reset_line_oe_n === 1'b0 && n < 200; n++) tick(1);
		check(n == behc_pkg::RSTI_CYC, "reset length");
		check(int_mask === behc_pkg::INT_MASK_RST && seq_step ===
			behc_pkg::SEQ_NONE && halted === 1'b0, "state kept");
		complete_run();
	end
endmodule // behc_ctrl_bench
